// *** stc_capture_in.sv ***
`timescale 1ns/1ps
// Capture trigger: source select, noise filter, edge detect
module stc_capture_in
(
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire stc_pkg::stc_cap_cfg_t cfg_i,
	input wire logic capture_input_pin_i,
	input wire logic comparator_out_i,
	output logic trig_o
);
	logic [stc_pkg::FILT_SAMPLES-1:0] hist_reg; // Recent samples
	logic [stc_pkg::FILT_SAMPLES-1:0] hist_next;
	logic lvl_reg; // Believed level of the trigger source
	logic lvl_next;
	logic src;

	// Filter costs a few cycles of latency but drops short spikes
	always_comb
	begin
		src = cfg_i.src_comp ? comparator_out_i : capture_input_pin_i;
		hist_next = {hist_reg[stc_pkg::FILT_SAMPLES-2:0], src};
		lvl_next = lvl_reg;
		if (!cfg_i.filt_en)
			lvl_next = src;
		else if (&hist_next)
			lvl_next = 1'b1;
		else if (~|hist_next)
			lvl_next = 1'b0;
	end

	// Register history and level
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			hist_reg <= stc_pkg::FILT_RST;
			lvl_reg <= 1'b0;
		end
		else
		begin
			hist_reg <= hist_next;
			lvl_reg <= lvl_next;
		end
	end

	// One pulse on the selected edge of the believed level
	assign trig_o = cfg_i.edge_rise ? (lvl_next & ~lvl_reg) :
		(~lvl_next & lvl_reg);
endmodule

// *** stc_cpu_model.sv ***
`timescale 1ns/1ps
// Software side of the register bus: byte transfers and word pairs
module stc_cpu_model
(
	input wire logic clk_sys_i,
	output logic psel_o = 1'b0,
	output logic penable_o = 1'b0,
	output logic pwrite_o = 1'b0,
	output logic [7:0] paddr_o = 8'h00,
	output logic [31:0] pwdata_o = 32'h0,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	// One transfer; the request holds until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic e);
		@(posedge clk_sys_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= {24'h0, d};
		@(posedge clk_sys_i);
		penable_o <= 1'b1;
		@(posedge clk_sys_i);
		// No wait count assumed: only the bench timeout ends a hang
		while (pready_i !== 1'b1)
			@(posedge clk_sys_i);
		q = prdata_i[7:0];
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released lines carry junk so nothing leans on old values
		paddr_o <= ~a;
		pwdata_o <= ~pwdata_o;
	endtask
	// Word write, high byte first; the high byte sits a word above
	// One caller only, so nothing can split the pair
	task automatic wr16(input logic [7:0] al, input logic [15:0] v);
		logic [7:0] q;
		logic e;
		xfer(1'b1, al + 8'h04, v[15:8], q, e);
		xfer(1'b1, al, v[7:0], q, e);
	endtask
	// Word read, low byte first so the high byte is frozen
	task automatic rd16(input logic [7:0] al, output logic [15:0] v);
		logic [7:0] q;
		logic e;
		xfer(1'b0, al, 8'h00, q, e);
		v[7:0] = q;
		xfer(1'b0, al + 8'h04, 8'h00, q, e);
		v[15:8] = q;
	endtask
endmodule

// *** stc_pkg.sv ***
// Notes on behaviour
// - Counter at floor when all bits zero
// - Ceiling is fixed maximum, compare A or capture register
// - Compare A ceiling in PWM: no output A
// - Compare A ceiling is double buffered in PWM modes only
// - Capture register may set fixed ceiling
// - Tick from prescaler or external pin edge
// - No clock source selected: counter holds
// - Compare registers matched against counter always
// - Each compare match on a tick sets its flag, except on the tick after a counter write
// - Capture counter on pin or comparator edge
// - Noise filter on the capture trigger
// - Four interrupt sources: overflow, A, B, capture
// - Flags visible; each masked by own bit
// - Control A and B are plain byte registers; C keeps only its source bit
// - One shared high byte holding register
// - Low byte write loads holding plus low
// - Low byte read copies high to holding
// - Compare reads bypass the holding register
// - Counter high location maps to holding register
// - CPU counter write beats clear and count
package stc_pkg;
	// Byte addresses of the word-aligned registers
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_CTRL_C = 8'h08;
	localparam logic [7:0] ADDR_FLAG = 8'h0c;
	localparam logic [7:0] ADDR_MASK = 8'h10;
	localparam logic [7:0] ADDR_CNT_LO = 8'h14;
	localparam logic [7:0] ADDR_CNT_HI = 8'h18;
	localparam logic [7:0] ADDR_CMPA_LO = 8'h1c;
	localparam logic [7:0] ADDR_CMPA_HI = 8'h20;
	localparam logic [7:0] ADDR_CMPB_LO = 8'h24;
	localparam logic [7:0] ADDR_CMPB_HI = 8'h28;
	localparam logic [7:0] ADDR_CAP_LO = 8'h2c;
	localparam logic [7:0] ADDR_CAP_HI = 8'h30;
	// Field positions in control A, B and C
	localparam int CTA_MODE_LSB = 0;
	localparam int CTA_OUTB_EN = 6;
	localparam int CTA_OUTA_EN = 7;
	localparam int CTB_CS_LSB = 0;
	localparam int CTB_EDGE = 6;
	localparam int CTB_FILT = 7;
	localparam int CTC_SRC = 0;
	localparam int CTC_FORCE_B = 6;
	localparam int CTC_FORCE_A = 7;
	// Bit positions in the flag and mask registers
	localparam int FLG_OVF = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CAP = 5;
	// Reset values and count limits
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] COUNT_FLOOR = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	// Prescaler width and divide shifts
	localparam int PRE_W = 10;
	localparam logic [PRE_W-1:0] PRE_RST = 10'h000;
	localparam int PRE_SH_8 = 3;
	localparam int PRE_SH_64 = 6;
	localparam int PRE_SH_256 = 8;
	localparam int PRE_SH_1024 = 10;
	// Equal samples needed before the capture input is believed
	localparam int FILT_SAMPLES = 4;
	localparam logic [FILT_SAMPLES-1:0] FILT_RST = 4'h0;

	// Counting modes, in the order of the mode field
	typedef enum logic [2:0] {
		STC_M_NORMAL,
		STC_M_CTC_A,
		STC_M_PWM_MAX,
		STC_M_PWM_A,
		STC_M_PWM_CAP,
		STC_M_CTC_CAP,
		STC_M_RSV6,
		STC_M_RSV7
	} stc_mode_t;

	// Clock source selections
	typedef enum logic [2:0] {
		STC_CS_OFF,
		STC_CS_DIV1,
		STC_CS_DIV8,
		STC_CS_DIV64,
		STC_CS_DIV256,
		STC_CS_DIV1024,
		STC_CS_EXT_FALL,
		STC_CS_EXT_RISE
	} stc_cs_t;

	// Capture trigger configuration
	typedef struct packed {
		logic edge_rise;
		logic filt_en;
		logic src_comp;
	} stc_cap_cfg_t;
endpackage

// *** stc_tick_gen.sv ***
`timescale 1ns/1ps
// Timer tick from the shared prescaler or the external count pin
module stc_tick_gen
(
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire stc_pkg::stc_cs_t cs_i,
	input wire logic external_count_pin_i,
	output logic timer_tick_o
);
	logic [stc_pkg::PRE_W-1:0] pre_reg; // Free running prescaler
	logic [stc_pkg::PRE_W-1:0] pre_next;
	logic pin_reg; // Last pin level, for edge detection
	logic pin_next;

	// All low bits set marks the last cycle of a divide period
	function automatic logic pre_hit(input logic [stc_pkg::PRE_W-1:0] p,
		input int sh);
		logic [stc_pkg::PRE_W-1:0] m;
		m = stc_pkg::PRE_W'((1 << sh) - 1);
		pre_hit = ((p & m) == m);
	endfunction

	// Next state of prescaler and pin history
	always_comb
	begin
		pre_next = pre_reg + 1'b1;
		pin_next = external_count_pin_i;
	end

	// Register the prescaler and pin history
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			pre_reg <= stc_pkg::PRE_RST;
			pin_reg <= 1'b0;
		end
		else
		begin
			pre_reg <= pre_next;
			pin_reg <= pin_next;
		end
	end

	// Source and edge selection
	always_comb
	begin
		case (cs_i)
			stc_pkg::STC_CS_OFF: timer_tick_o = 1'b0; // Stopped
			stc_pkg::STC_CS_DIV1: timer_tick_o = 1'b1;
			stc_pkg::STC_CS_DIV8:
				timer_tick_o = pre_hit(pre_reg, stc_pkg::PRE_SH_8);
			stc_pkg::STC_CS_DIV64:
				timer_tick_o = pre_hit(pre_reg, stc_pkg::PRE_SH_64);
			stc_pkg::STC_CS_DIV256:
				timer_tick_o = pre_hit(pre_reg, stc_pkg::PRE_SH_256);
			stc_pkg::STC_CS_DIV1024:
				timer_tick_o = pre_hit(pre_reg, stc_pkg::PRE_SH_1024);
			stc_pkg::STC_CS_EXT_FALL:
				timer_tick_o = pin_reg & ~external_count_pin_i;
			stc_pkg::STC_CS_EXT_RISE:
				timer_tick_o = ~pin_reg & external_count_pin_i;
			default: timer_tick_o = 1'b0;
		endcase
	end
endmodule

// *** stc_timer.sv ***
`timescale 1ns/1ps
// Sixteen bit timer core with APB register access
module stc_timer
(
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic external_count_pin_i,
	input wire logic capture_input_pin_i,
	input wire logic comparator_out_i,
	output logic compare_output_a_o,
	output logic compare_output_b_o,
	output logic match_a_o,
	output logic match_b_o,
	output logic count_floor_o,
	output logic [3:0] irq_req_o
);
	// Control and status
	logic [7:0] ctl_a_reg; // Mode and output enables
	logic [7:0] ctl_a_next;
	logic [7:0] ctl_b_reg; // Clock select and capture setup
	logic [7:0] ctl_b_next;
	logic ctl_c_src_reg; // Capture source, comparator when set
	logic ctl_c_src_next;
	logic [7:0] flg_reg; // Sticky event flags
	logic [7:0] flg_next;
	logic [7:0] msk_reg; // Per flag request mask
	logic [7:0] msk_next;
	// Sixteen bit values
	logic [15:0] cnt_reg; // Counter
	logic [15:0] cnt_next;
	logic [15:0] cmpa_buf_reg; // Compare A as software wrote it
	logic [15:0] cmpa_buf_next;
	logic [15:0] cmpa_act_reg; // Compare A in use
	logic [15:0] cmpa_act_next;
	logic [15:0] cmpb_buf_reg;
	logic [15:0] cmpb_buf_next;
	logic [15:0] cmpb_act_reg;
	logic [15:0] cmpb_act_next;
	logic [15:0] cap_reg; // Capture register
	logic [15:0] cap_next;
	logic [7:0] temp_reg; // Shared high byte holding register
	logic [7:0] temp_next;
	logic blk_reg; // Match suppressed on the tick after a counter write
	logic blk_next;
	logic outa_reg; // Compare output A level
	logic outa_next;
	logic outb_reg;
	logic outb_next;
	// Bus read side
	logic [7:0] rdat_reg; // Byte sampled in the setup cycle
	logic [7:0] rdat_next;
	logic [7:0] rdhi_reg; // High byte sampled with it
	logic [7:0] rdhi_next;
	logic err_reg; // Unmapped address seen in setup
	logic err_next;
	// Combinational helpers
	stc_pkg::stc_mode_t mode;
	stc_pkg::stc_cap_cfg_t cap_cfg;
	logic tick;
	logic trig;
	logic pwm;
	logic [15:0] top;
	logic [15:0] cmpa_use;
	logic [15:0] cmpb_use;
	logic wr_acc;
	logic rd_acc;
	logic [7:0] wbyte;
	logic [7:0] set_v;

	// PWM modes load compare values only at the ceiling
	function automatic logic is_pwm(input stc_pkg::stc_mode_t m);
		is_pwm = (m == stc_pkg::STC_M_PWM_MAX) ||
			(m == stc_pkg::STC_M_PWM_A) || (m == stc_pkg::STC_M_PWM_CAP);
	endfunction

	// Whether an address is one of ours
	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			stc_pkg::ADDR_CTRL_A, stc_pkg::ADDR_CTRL_B,
			stc_pkg::ADDR_CTRL_C, stc_pkg::ADDR_FLAG,
			stc_pkg::ADDR_MASK, stc_pkg::ADDR_CNT_LO,
			stc_pkg::ADDR_CNT_HI, stc_pkg::ADDR_CMPA_LO,
			stc_pkg::ADDR_CMPA_HI, stc_pkg::ADDR_CMPB_LO,
			stc_pkg::ADDR_CMPB_HI, stc_pkg::ADDR_CAP_LO,
			stc_pkg::ADDR_CAP_HI: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	assign mode = stc_pkg::stc_mode_t'(ctl_a_reg[stc_pkg::CTA_MODE_LSB +: 3]);
	assign cap_cfg = '{edge_rise: ctl_b_reg[stc_pkg::CTB_EDGE],
		filt_en: ctl_b_reg[stc_pkg::CTB_FILT], src_comp: ctl_c_src_reg};
	assign pwm = is_pwm(mode);

	// Timer tick source
	stc_tick_gen u_tick
	(
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.cs_i(stc_pkg::stc_cs_t'(ctl_b_reg[stc_pkg::CTB_CS_LSB +: 3])),
		.external_count_pin_i(external_count_pin_i),
		.timer_tick_o(tick)
	);

	// Capture trigger path
	stc_capture_in u_cap
	(
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.cfg_i(cap_cfg),
		.capture_input_pin_i(capture_input_pin_i),
		.comparator_out_i(comparator_out_i),
		.trig_o(trig)
	);

	// Compare values in use and the ceiling of the count sequence
	always_comb
	begin
		cmpa_use = pwm ? cmpa_act_reg : cmpa_buf_reg;
		cmpb_use = pwm ? cmpb_act_reg : cmpb_buf_reg;
		case (mode)
			stc_pkg::STC_M_CTC_A, stc_pkg::STC_M_PWM_A:
				top = cmpa_use;
			stc_pkg::STC_M_PWM_CAP, stc_pkg::STC_M_CTC_CAP:
				top = cap_reg;
			default: top = stc_pkg::COUNT_MAX;
		endcase
	end

	// Continuous match results for the waveform side
	assign match_a_o = (cnt_reg == cmpa_use);
	assign match_b_o = (cnt_reg == cmpb_use);
	assign count_floor_o = (cnt_reg == stc_pkg::COUNT_FLOOR);

	// Timer state: counting, compare, capture and register writes
	always_comb
	begin
		ctl_a_next = ctl_a_reg;
		ctl_b_next = ctl_b_reg;
		ctl_c_src_next = ctl_c_src_reg;
		msk_next = msk_reg;
		cnt_next = cnt_reg;
		cmpa_buf_next = cmpa_buf_reg;
		cmpb_buf_next = cmpb_buf_reg;
		cmpa_act_next = pwm ? cmpa_act_reg : cmpa_buf_reg;
		cmpb_act_next = pwm ? cmpb_act_reg : cmpb_buf_reg;
		cap_next = cap_reg;
		temp_next = temp_reg;
		blk_next = blk_reg;
		outa_next = outa_reg;
		outb_next = outb_reg;
		set_v = 8'h00;
		wr_acc = psel_i & penable_i & pwrite_i;
		rd_acc = psel_i & penable_i & ~pwrite_i;
		wbyte = pwdata_i[7:0];
		// Counting happens only on a tick
		if (tick)
		begin
			blk_next = 1'b0;
			if (cnt_reg == top)
			begin
				cnt_next = stc_pkg::COUNT_FLOOR;
				if (pwm)
				begin
					cmpa_act_next = cmpa_buf_reg;
					cmpb_act_next = cmpb_buf_reg;
				end
			end
			else
				cnt_next = cnt_reg + 16'h0001;
			if ((cnt_reg == stc_pkg::COUNT_MAX) || (pwm && cnt_reg == top))
				set_v[stc_pkg::FLG_OVF] = 1'b1;
			if (!blk_reg && match_a_o)
			begin
				set_v[stc_pkg::FLG_CMPA] = 1'b1;
				outa_next = pwm ? 1'b0 : ~outa_reg;
			end
			if (!blk_reg && match_b_o)
			begin
				set_v[stc_pkg::FLG_CMPB] = 1'b1;
				outb_next = pwm ? 1'b0 : ~outb_reg;
			end
			// PWM outputs rise when the count restarts at the floor
			if (pwm && cnt_reg == top)
			begin
				outa_next = 1'b1;
				outb_next = 1'b1;
			end
		end
		// Capture is off while the capture register is the ceiling
		if (trig && mode != stc_pkg::STC_M_PWM_CAP &&
			mode != stc_pkg::STC_M_CTC_CAP)
		begin
			cap_next = cnt_reg;
			set_v[stc_pkg::FLG_CAP] = 1'b1;
		end
		// Software write, after the hardware updates so that it wins
		if (wr_acc)
		begin
			case (paddr_i)
				stc_pkg::ADDR_CTRL_A: ctl_a_next = wbyte;
				stc_pkg::ADDR_CTRL_B: ctl_b_next = wbyte;
				stc_pkg::ADDR_CTRL_C:
				begin
					ctl_c_src_next = wbyte[stc_pkg::CTC_SRC];
					// Forced match changes the pin only, no flag
					if (wbyte[stc_pkg::CTC_FORCE_A] && !pwm)
						outa_next = ~outa_reg;
					if (wbyte[stc_pkg::CTC_FORCE_B] && !pwm)
						outb_next = ~outb_reg;
				end
				stc_pkg::ADDR_MASK: msk_next = wbyte;
				stc_pkg::ADDR_CNT_HI, stc_pkg::ADDR_CMPA_HI,
				stc_pkg::ADDR_CMPB_HI, stc_pkg::ADDR_CAP_HI:
					temp_next = wbyte;
				stc_pkg::ADDR_CNT_LO:
				begin
					cnt_next = {temp_reg, wbyte};
					blk_next = 1'b1;
				end
				stc_pkg::ADDR_CMPA_LO: cmpa_buf_next = {temp_reg, wbyte};
				stc_pkg::ADDR_CMPB_LO: cmpb_buf_next = {temp_reg, wbyte};
				stc_pkg::ADDR_CAP_LO: cap_next = {temp_reg, wbyte};
				default: ;
			endcase
		end
		// Low byte reads of routed registers fill the holding register
		if (rd_acc && (paddr_i == stc_pkg::ADDR_CNT_LO ||
			paddr_i == stc_pkg::ADDR_CAP_LO))
			temp_next = rdhi_reg;
		// Output A is no waveform while it sets the PWM ceiling
		if (!ctl_a_reg[stc_pkg::CTA_OUTA_EN] || mode == stc_pkg::STC_M_PWM_A)
			outa_next = 1'b0;
		if (!ctl_a_reg[stc_pkg::CTA_OUTB_EN])
			outb_next = 1'b0;
		// Write one to clear; a same-cycle event keeps its flag set
		flg_next = flg_reg | set_v;
		if (wr_acc && paddr_i == stc_pkg::ADDR_FLAG)
			flg_next = (flg_reg & ~wbyte) | set_v;
	end

	// Register the timer state
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			ctl_a_reg <= stc_pkg::RST_BYTE;
			ctl_b_reg <= stc_pkg::RST_BYTE;
			ctl_c_src_reg <= 1'b0;
			flg_reg <= stc_pkg::RST_BYTE;
			msk_reg <= stc_pkg::RST_BYTE;
			cnt_reg <= stc_pkg::RST_WORD;
			cmpa_buf_reg <= stc_pkg::RST_WORD;
			cmpa_act_reg <= stc_pkg::RST_WORD;
			cmpb_buf_reg <= stc_pkg::RST_WORD;
			cmpb_act_reg <= stc_pkg::RST_WORD;
			cap_reg <= stc_pkg::RST_WORD;
			temp_reg <= stc_pkg::RST_BYTE;
			blk_reg <= 1'b0;
			outa_reg <= 1'b0;
			outb_reg <= 1'b0;
		end
		else
		begin
			ctl_a_reg <= ctl_a_next;
			ctl_b_reg <= ctl_b_next;
			ctl_c_src_reg <= ctl_c_src_next;
			flg_reg <= flg_next;
			msk_reg <= msk_next;
			cnt_reg <= cnt_next;
			cmpa_buf_reg <= cmpa_buf_next;
			cmpa_act_reg <= cmpa_act_next;
			cmpb_buf_reg <= cmpb_buf_next;
			cmpb_act_reg <= cmpb_act_next;
			cap_reg <= cap_next;
			temp_reg <= temp_next;
			blk_reg <= blk_next;
			outa_reg <= outa_next;
			outb_reg <= outb_next;
		end
	end

	// Read byte chosen in the setup cycle so the data is a flop
	always_comb
	begin
		rdat_next = rdat_reg;
		rdhi_next = rdhi_reg;
		err_next = err_reg;
		if (psel_i && !penable_i)
		begin
			err_next = ~is_mapped(paddr_i);
			rdhi_next = (paddr_i == stc_pkg::ADDR_CAP_LO) ? cap_reg[15:8] :
				cnt_reg[15:8];
			case (paddr_i)
				stc_pkg::ADDR_CTRL_A: rdat_next = ctl_a_reg;
				stc_pkg::ADDR_CTRL_B: rdat_next = ctl_b_reg;
				stc_pkg::ADDR_CTRL_C:
					rdat_next = {7'h00, ctl_c_src_reg};
				stc_pkg::ADDR_FLAG: rdat_next = flg_reg;
				stc_pkg::ADDR_MASK: rdat_next = msk_reg;
				stc_pkg::ADDR_CNT_LO: rdat_next = cnt_reg[7:0];
				stc_pkg::ADDR_CNT_HI, stc_pkg::ADDR_CAP_HI:
					rdat_next = temp_reg;
				stc_pkg::ADDR_CMPA_LO: rdat_next = cmpa_buf_reg[7:0];
				stc_pkg::ADDR_CMPA_HI: rdat_next = cmpa_buf_reg[15:8];
				stc_pkg::ADDR_CMPB_LO: rdat_next = cmpb_buf_reg[7:0];
				stc_pkg::ADDR_CMPB_HI: rdat_next = cmpb_buf_reg[15:8];
				stc_pkg::ADDR_CAP_LO: rdat_next = cap_reg[7:0];
				default: rdat_next = 8'h00;
			endcase
		end
	end

	// Register the read side
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			rdat_reg <= stc_pkg::RST_BYTE;
			rdhi_reg <= stc_pkg::RST_BYTE;
			err_reg <= 1'b0;
		end
		else
		begin
			rdat_reg <= rdat_next;
			rdhi_reg <= rdhi_next;
			err_reg <= err_next;
		end
	end

	// Bus answers in the first access cycle
	assign prdata_o = {24'h000000, rdat_reg};
	assign pready_o = 1'b1;
	assign pslverr_o = err_reg & psel_i & penable_i;
	assign compare_output_a_o = outa_reg;
	assign compare_output_b_o = outb_reg;

	// Each request gated by its own mask bit
	assign irq_req_o = {flg_reg[stc_pkg::FLG_CAP] & msk_reg[stc_pkg::FLG_CAP],
		flg_reg[stc_pkg::FLG_CMPB] & msk_reg[stc_pkg::FLG_CMPB],
		flg_reg[stc_pkg::FLG_CMPA] & msk_reg[stc_pkg::FLG_CMPA],
		flg_reg[stc_pkg::FLG_OVF] & msk_reg[stc_pkg::FLG_OVF]};
endmodule

// *** stc_timer_sva.sv ***
`timescale 1ns/1ps
// Checks on the timer top, made only from its ports
module stc_timer_sva
(
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic compare_output_a_o,
	input wire logic compare_output_b_o,
	input wire logic count_floor_o,
	input wire logic [3:0] irq_req_o
);
	// Access phase decode
	logic acc, wr_acc, rd_acc, mapped, hi_wr, lo_rd;
	// Shadows of what software last wrote
	logic [7:0] hold_reg, hold_next, ctla_reg, ctla_next;
	logic [7:0] mask_reg, mask_next;
	// The holding byte is known only until hardware reloads it
	logic ok_reg, ok_next;
	assign acc = psel_i && penable_i;
	assign wr_acc = acc && pwrite_i;
	assign rd_acc = acc && !pwrite_i;
	assign mapped = paddr_i[1:0] == 2'h0 && paddr_i <= 8'h30;
	// High-byte locations of the four word registers
	assign hi_wr = wr_acc && paddr_i inside {8'h18, 8'h20, 8'h28, 8'h30};
	// Low-byte reads of counter or capture refill it from hardware
	assign lo_rd = rd_acc && paddr_i inside {8'h14, 8'h2c};
	// Next shadow values
	always_comb
	begin
		hold_next = hi_wr ? pwdata_i[7:0] : hold_reg;
		ok_next = hi_wr || (ok_reg && !lo_rd);
		ctla_next = (wr_acc && paddr_i == 8'h00) ? pwdata_i[7:0] : ctla_reg;
		mask_next = (wr_acc && paddr_i == 8'h10) ? pwdata_i[7:0] : mask_reg;
	end
	// Shadow registers, zero after reset like the block; ok flag starts set
	always_ff @(posedge clk_sys_i)
	begin
		hold_reg <= rstn_i ? hold_next : 8'h00;
		ok_reg <= rstn_i ? ok_next : 1'b1;
		ctla_reg <= rstn_i ? ctla_next : 8'h00;
		mask_reg <= rstn_i ? mask_next : 8'h00;
	end
	default clocking dc @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	AST_READY: assert property (acc |-> pready_o)
		else $error("pready low in access phase");
	AST_ERR_MAP: assert property (acc |-> pslverr_o == !mapped)
		else $error("error response wrong for address");
	AST_ERR_IDLE: assert property (!acc |-> !pslverr_o)
		else $error("error response outside access");
	AST_UNMAP_RD: assert property (rd_acc && !mapped |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (acc |=> $stable(prdata_o))
		else $error("read data moved after access");
	AST_HOLD_RD: assert property (rd_acc && ok_reg &&
		paddr_i inside {8'h18, 8'h30} |-> prdata_o == {24'h0, hold_reg})
		else $error("high byte read not from holding byte");
	AST_CTRL_RD: assert property (rd_acc && paddr_i == 8'h00
		|-> prdata_o == {24'h0, ctla_reg})
		else $error("control byte read back wrong");
	AST_MASK_RD: assert property (rd_acc && paddr_i == 8'h10
		|-> prdata_o == {24'h0, mask_reg})
		else $error("mask byte read back wrong");
	AST_IRQ_GATE: assert property (
		(irq_req_o & ~{mask_reg[5], mask_reg[2:0]}) == 4'h0)
		else $error("request passed a cleared mask bit");
	AST_CNT_LOAD: assert property (wr_acc && paddr_i == 8'h14 && ok_reg
		|=> count_floor_o == ($past(hold_reg) == 8'h00 &&
		($past(pwdata_i) & 32'hff) == 32'h0))
		else $error("counter word load wrong");
	AST_RESET_OUT: assert property ($rose(rstn_i) |-> count_floor_o &&
		irq_req_o == 4'h0 && !compare_output_a_o && !compare_output_b_o)
		else $error("outputs not at reset state");
endmodule
bind stc_timer stc_timer_sva chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o),
	.compare_output_a_o(compare_output_a_o),
	.compare_output_b_o(compare_output_b_o),
	.count_floor_o(count_floor_o), .irq_req_o(irq_req_o));

// *** stc_timer_test.sv ***
`timescale 1ns/1ps
// Register-level test of the timer through its bus and pins
module stc_timer_test;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	// Bus between the software model and the timer
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	// Pins driven by the bench, and timer outputs
	logic ext_pin = 1'b0;
	logic cap_pin = 1'b0;
	logic comp = 1'b0;
	logic out_a, out_b, m_a, m_b, floor_o, e, sa, sb;
	logic [3:0] irq;
	logic [7:0] q;
	logic [15:0] w;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int i;
	always #12.5 clk_sys_i = ~clk_sys_i;
	stc_timer dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .external_count_pin_i(ext_pin),
		.capture_input_pin_i(cap_pin), .comparator_out_i(comp),
		.compare_output_a_o(out_a), .compare_output_b_o(out_b),
		.match_a_o(m_a), .match_b_o(m_b), .count_floor_o(floor_o),
		.irq_req_o(irq));
	stc_cpu_model cpu (.clk_sys_i(clk_sys_i), .psel_o(psel),
		.penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
		.pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr));
	// Compare and count; a mismatch is reported at once
	task automatic chk(input logic [15:0] seen, exp, input string nm);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		cpu.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, x, input string nm);
		cpu.xfer(1'b0, a, 8'h00, q, e);
		chk(q, x, nm);
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic close_out;
		$display("Compares %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard: the run needs well under a thousand cycles
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			close_out();
		end
	end
	initial
	begin
		ticks(8);
		rstn_i <= 1'b1;
		// Every register reads zero out of reset
		for (i = 0; i < 13; i++)
			rd(8'(i * 4), 8'h00, "reset");
		chk(floor_o, 1'b1, "floor");
		wr(stc_pkg::ADDR_CTRL_A, 8'hc5);
		rd(stc_pkg::ADDR_CTRL_A, 8'hc5, "ctla");
		wr(stc_pkg::ADDR_CTRL_B, 8'hc0);
		rd(stc_pkg::ADDR_CTRL_B, 8'hc0, "ctlb");
		wr(stc_pkg::ADDR_CTRL_A, 8'h00);
		wr(stc_pkg::ADDR_CTRL_B, 8'h00);
		// Counter word with no clock source: it must not move
		cpu.wr16(stc_pkg::ADDR_CNT_LO, 16'h1234);
		ticks(20);
		cpu.rd16(stc_pkg::ADDR_CNT_LO, w);
		chk(w, 16'h1234, "cnt");
		chk(floor_o, 1'b0, "floor");
		// One holding byte shared by all word registers
		wr(stc_pkg::ADDR_CNT_HI, 8'h56);
		rd(stc_pkg::ADDR_CAP_HI, 8'h56, "caph");
		wr(stc_pkg::ADDR_CMPA_LO, 8'h78);
		wr(stc_pkg::ADDR_CMPB_HI, 8'h9a);
		wr(stc_pkg::ADDR_CMPB_LO, 8'hbc);
		rd(stc_pkg::ADDR_CNT_LO, 8'h34, "cntl");
		rd(stc_pkg::ADDR_CMPA_HI, 8'h56, "cmpah");
		rd(stc_pkg::ADDR_CMPB_HI, 8'h9a, "cmpbh");
		rd(stc_pkg::ADDR_CMPA_LO, 8'h78, "cmpal");
		rd(stc_pkg::ADDR_CNT_HI, 8'h12, "cnth");
		// PWM with compare A as ceiling: output A stays quiet
		cpu.wr16(stc_pkg::ADDR_CMPA_LO, 16'h0010);
		cpu.wr16(stc_pkg::ADDR_CMPB_LO, 16'h0008);
		// Counter parked on compare B: only match B is high
		cpu.wr16(stc_pkg::ADDR_CNT_LO, 16'h0008);
		@(negedge clk_sys_i);
		chk({m_a, m_b}, 2'b01, "match");
		cpu.wr16(stc_pkg::ADDR_CNT_LO, 16'h0000);
		wr(stc_pkg::ADDR_FLAG, 8'hff);
		wr(stc_pkg::ADDR_MASK, 8'h21);
		wr(stc_pkg::ADDR_CTRL_A, 8'hc3);
		wr(stc_pkg::ADDR_CTRL_B, 8'h01);
		sa = 1'b0;
		sb = 1'b0;
		repeat (100)
		begin
			@(negedge clk_sys_i);
			sa = sa | out_a;
			sb = sb | out_b;
		end
		wr(stc_pkg::ADDR_CTRL_B, 8'h00);
		chk(sa, 1'b0, "outa");
		chk(sb, 1'b1, "outb");
		rd(stc_pkg::ADDR_FLAG, 8'h07, "flags");
		chk(irq, 4'h1, "irq");
		cpu.rd16(stc_pkg::ADDR_CNT_LO, w);
		chk(w <= 16'h0010, 1'b1, "top");
		wr(stc_pkg::ADDR_FLAG, 8'h02);
		rd(stc_pkg::ADDR_FLAG, 8'h05, "w1c");
		// External pin, falling then rising edge selected
		wr(stc_pkg::ADDR_CTRL_A, 8'h00);
		for (i = 6; i < 8; i++)
		begin
			cpu.wr16(stc_pkg::ADDR_CNT_LO, 16'h0000);
			wr(stc_pkg::ADDR_CTRL_B, 8'(i));
			repeat (5)
			begin
				ext_pin <= 1'b1;
				ticks(3);
				ext_pin <= 1'b0;
				ticks(3);
			end
			wr(stc_pkg::ADDR_CTRL_B, 8'h00);
			cpu.rd16(stc_pkg::ADDR_CNT_LO, w);
			chk(w, 16'h0005, "ext");
		end
		// Capture from the pin, then from the comparator
		cpu.wr16(stc_pkg::ADDR_CNT_LO, 16'h0000);
		wr(stc_pkg::ADDR_CTRL_B, 8'h41);
		ticks(10);
		cap_pin <= 1'b1;
		ticks(4);
		wr(stc_pkg::ADDR_CTRL_B, 8'h00);
		cpu.rd16(stc_pkg::ADDR_CAP_LO, w);
		chk(w > 16'h0009 && w < 16'h0020, 1'b1, "cap");
		rd(stc_pkg::ADDR_FLAG, 8'h27, "capf");
		// Switching the source can fake an edge, so clear flags after it
		wr(stc_pkg::ADDR_CTRL_C, 8'h01);
		wr(stc_pkg::ADDR_CTRL_B, 8'h40);
		wr(stc_pkg::ADDR_FLAG, 8'hff);
		ticks(4);
		comp <= 1'b1;
		ticks(4);
		rd(stc_pkg::ADDR_FLAG, 8'h20, "cmpf");
		// Filter drops a two-cycle spike, keeps a steady level
		wr(stc_pkg::ADDR_CTRL_C, 8'h00);
		cap_pin <= 1'b0;
		wr(stc_pkg::ADDR_CTRL_B, 8'hc0);
		ticks(10);
		wr(stc_pkg::ADDR_FLAG, 8'hff);
		cap_pin <= 1'b1;
		ticks(2);
		cap_pin <= 1'b0;
		ticks(10);
		rd(stc_pkg::ADDR_FLAG, 8'h00, "spike");
		cap_pin <= 1'b1;
		ticks(10);
		rd(stc_pkg::ADDR_FLAG, 8'h20, "level");
		// Capture register as a fixed ceiling of the count
		cpu.wr16(stc_pkg::ADDR_CAP_LO, 16'h0004);
		cpu.wr16(stc_pkg::ADDR_CNT_LO, 16'h0000);
		wr(stc_pkg::ADDR_CTRL_A, 8'h05);
		wr(stc_pkg::ADDR_CTRL_B, 8'h01);
		ticks(30);
		wr(stc_pkg::ADDR_CTRL_B, 8'h00);
		cpu.rd16(stc_pkg::ADDR_CNT_LO, w);
		chk(w <= 16'h0004, 1'b1, "captop");
		// Unmapped address: write dropped, read zero with error
		cpu.xfer(1'b1, 8'h34, 8'hff, q, e);
		chk(e, 1'b1, "werr");
		rd(8'h34, 8'h00, "unmap");
		chk(e, 1'b1, "rerr");
		close_out();
	end
endmodule
